// File: logic/dptp_pkg.sv
// Constants, register map and carrier types for the dual pair timer block.
// Assumes a 32-bit APB master and that core_clk stands in for the crystal clock.
package dptp_pkg;

  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int unsigned DPTP_ADDR_W = 12;
  localparam logic [DPTP_ADDR_W-1:0] DPTP_OFS_CTRL   = 12'h000;
  localparam logic [DPTP_ADDR_W-1:0] DPTP_OFS_CNT01  = 12'h004;
  localparam logic [DPTP_ADDR_W-1:0] DPTP_OFS_CNT23  = 12'h008;
  localparam logic [DPTP_ADDR_W-1:0] DPTP_OFS_RLDLO  = 12'h00C;
  localparam logic [DPTP_ADDR_W-1:0] DPTP_OFS_RLDHI  = 12'h010;
  localparam logic [DPTP_ADDR_W-1:0] DPTP_OFS_RLD23  = 12'h014;
  localparam logic [DPTP_ADDR_W-1:0] DPTP_OFS_STAT   = 12'h018;
  // Port B registers keep their printed index; byte address is four times it
  localparam logic [7:0] DPTP_IDX_PB_DIR = 8'hD6;
  localparam logic [7:0] DPTP_IDX_PB_SFR = 8'hD7;
  localparam logic [DPTP_ADDR_W-1:0] DPTP_OFS_PB_DIR = {2'b00, DPTP_IDX_PB_DIR, 2'b00};
  localparam logic [DPTP_ADDR_W-1:0] DPTP_OFS_PB_SFR = {2'b00, DPTP_IDX_PB_SFR, 2'b00};

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned DPTP_TOGGLE_OUTPUT_MODE_BIT   = 1;
  localparam int unsigned DPTP_STAT_PHASE = 0;
  localparam int unsigned DPTP_STAT_TOG   = 1;
  localparam int unsigned DPTP_STAT_FIRST = 2;
  localparam logic [5:0]  DPTP_CTRL_RST   = 6'h00;
  localparam logic [7:0]  DPTP_BYTE_RST   = 8'h00;
  localparam logic [15:0] DPTP_WORD_RST   = 16'h0000;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned DPTP_PRESC_DIV = 8;
  localparam logic [2:0]  DPTP_PRESC_MAX = 3'(DPTP_PRESC_DIV - 1);

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [DPTP_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata;
  } dptp_apb_req_s;

  typedef struct packed {
    logic rld1;
    logic rld0;
    logic casc;
    logic en23;
    logic en1;
    logic en0;
  } dptp_ctrl_s;

  typedef enum logic [1:0] {
    DPTP_LOAD_LO = 2'b01,
    DPTP_LOAD_HI = 2'b10
  } dptp_phase_e;

endpackage

// File: logic/dptp_timer.sv
// Four 8-bit down-counters as one 8/8/16-bit PWM pair and one 16-bit pair.
// Assumes an APB master on core_clk and an asynchronous timer_output_pin.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps

// Behaviour
// - First pair runs as two 8-bit timers or one cascaded 16-bit PWM timer.
// - Second pair only ever runs as one cascaded 16-bit timer.
// - A 16-bit pair interrupts only at full zero; the second pair on its own line.
// - Even timer holds the low count byte, odd timer the high byte.
// - Unless reload is off, on interrupt the count is loaded from the reload register at once.
// - 16-bit pairs always reload at timeout whatever the reload option.
// - 16-bit timers keep counting while a request is pending, independently.
// - A second zero before service needs no detection or flag.
// - Control write starts enabled timers from their count, no reload.
// - Internal clock only; enabled timers step once every 8 clocks.
// - Independent 8-bit timers use own reload byte, reload only if enabled.
// - PWM low reload is odd:even low bytes, high reload odd:even high bytes.
// - PWM alternates low and high reloads at each timeout.
// - PWM starts from count; first reload by pin in toggle mode, else low.
// - End of low period raises even interrupt, end of high the odd one.
// - Each end-of-count of the even first-pair timer toggles the output.
// - In PWM toggle mode pin falls after high period, rises after low.
// - After reset all timers are disabled until the control write.
module dptp_timer (
  // Clock and reset
  input  wire  logic                     core_clk,
  input  wire  logic                     sys_rst,
  // APB slave
  input  wire  dptp_pkg::dptp_apb_req_s  apb_req,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // Timer output pin
  input  wire  logic                     timer_output_pin_i,
  output logic                           timer_output_pin_o,
  output logic                           timer_output_pin_oe,
  // Interrupt request pulses
  output logic                           even_timer_interrupt,
  output logic                           odd_timer_interrupt,
  output logic                           second_pair_interrupt
);
  import dptp_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  // One counting step; zero passes to reload or wraps to all ones
  function automatic logic [15:0] dptp_step(input logic [15:0] cnt,
                                            input logic [15:0] rld,
                                            input logic        rld_en);
    if (cnt == 16'h0000) begin
      dptp_step = rld_en ? rld : 16'hFFFF;
    end else begin
      dptp_step = cnt - 16'h0001;
    end
  endfunction

  function automatic logic dptp_hit(input dptp_apb_req_s r,
                                    input logic [DPTP_ADDR_W-1:0] ofs);
    dptp_hit = (r.paddr == ofs);
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  dptp_ctrl_s        ctrl_ff;
  logic [7:0]        cnt0_ff;
  logic [7:0]        cnt1_ff;
  logic [15:0]       cnt23_ff;
  logic [15:0]       rld_lo_ff;
  logic [15:0]       rld_hi_ff;
  logic [15:0]       rld23_ff;
  logic [7:0]        pb_dir_ff;
  logic [7:0]        pb_sfr_ff;
  logic [2:0]        presc_ff;
  dptp_phase_e       phase_ff;
  logic              first_ff;
  logic              tog_ff;
  logic              pin_meta_ff;
  logic              pin_sync_ff;
  logic              irq_even_ff;
  logic              irq_odd_ff;
  logic              irq23_ff;
  logic [31:0]       prdata_ff;
  logic              slverr_ff;

  logic              setup;
  logic              wr;
  logic              wr_ctrl;
  logic              wr_cnt01;
  logic              wr_cnt23;
  logic              tick;
  logic              toggle_output_mode_mode;
  logic [15:0]       cnt01;
  logic              to0;
  logic              to1;
  logic              to01;
  logic              to23;
  logic              sel_hi;
  logic [15:0]       nxt_cnt01;
  logic [31:0]       rd_val;
  logic              rd_ok;

  // ************************************************************
  // APB slave
  // ************************************************************
  // Zero wait states; read data and error are captured in the setup cycle
  assign setup    = apb_req.psel & ~apb_req.penable;
  assign wr       = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign wr_ctrl  = wr & dptp_hit(apb_req, DPTP_OFS_CTRL);
  assign wr_cnt01 = wr & dptp_hit(apb_req, DPTP_OFS_CNT01);
  assign wr_cnt23 = wr & dptp_hit(apb_req, DPTP_OFS_CNT23);
  assign pready   = 1'b1;
  assign prdata   = prdata_ff;
  assign pslverr  = slverr_ff & apb_req.psel & apb_req.penable;

  // Read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (apb_req.paddr)
      DPTP_OFS_CTRL:   rd_val = {26'h000_0000, ctrl_ff};
      DPTP_OFS_CNT01:  rd_val = {16'h0000, cnt1_ff, cnt0_ff};
      DPTP_OFS_CNT23:  rd_val = {16'h0000, cnt23_ff};
      DPTP_OFS_RLDLO:  rd_val = {16'h0000, rld_lo_ff};
      DPTP_OFS_RLDHI:  rd_val = {16'h0000, rld_hi_ff};
      DPTP_OFS_RLD23:  rd_val = {16'h0000, rld23_ff};
      DPTP_OFS_STAT: begin
        rd_val[DPTP_STAT_PHASE] = (phase_ff == DPTP_LOAD_HI);
        rd_val[DPTP_STAT_TOG]   = tog_ff;
        rd_val[DPTP_STAT_FIRST] = first_ff;
      end
      DPTP_OFS_PB_DIR: rd_val = {24'h00_0000, pb_dir_ff};
      DPTP_OFS_PB_SFR: rd_val = {24'h00_0000, pb_sfr_ff};
      default:         rd_ok  = 1'b0;
    endcase
  end

  // Capture answer while the master holds the setup cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= apb_req.pwrite ? 32'h0000_0000 : rd_val;
      slverr_ff <= ~rd_ok;
    end
  end

  // Configuration registers; reset leaves every timer disabled
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_ff   <= DPTP_CTRL_RST;
      rld_lo_ff <= DPTP_WORD_RST;
      rld_hi_ff <= DPTP_WORD_RST;
      rld23_ff  <= DPTP_WORD_RST;
      pb_dir_ff <= DPTP_BYTE_RST;
      pb_sfr_ff <= DPTP_BYTE_RST;
    end else if (wr) begin
      case (apb_req.paddr)
        DPTP_OFS_CTRL:   ctrl_ff   <= apb_req.pwdata[5:0];
        DPTP_OFS_RLDLO:  rld_lo_ff <= apb_req.pwdata[15:0];
        DPTP_OFS_RLDHI:  rld_hi_ff <= apb_req.pwdata[15:0];
        DPTP_OFS_RLD23:  rld23_ff  <= apb_req.pwdata[15:0];
        DPTP_OFS_PB_DIR: pb_dir_ff <= apb_req.pwdata[7:0];
        DPTP_OFS_PB_SFR: pb_sfr_ff <= apb_req.pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Prescaler and pin input
  // ************************************************************
  // Restart on control write so counting begins a full period later
  always_ff @(posedge core_clk) begin
    if (sys_rst || wr_ctrl) begin
      presc_ff <= 3'h0;
    end else begin
      presc_ff <= presc_ff + 3'h1;
    end
  end
  assign tick = (presc_ff == DPTP_PRESC_MAX);

  // Two-flop synchroniser for the pad level
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= timer_output_pin_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ************************************************************
  // Timeout detection
  // ************************************************************
  assign cnt01 = {cnt1_ff, cnt0_ff};
  // Control write cycle never counts, so no reload comes from it
  assign to0   = tick & ~wr_ctrl & ctrl_ff.en0 & ~ctrl_ff.casc & (cnt0_ff == 8'h00);
  assign to1   = tick & ~wr_ctrl & ctrl_ff.en1 & ~ctrl_ff.casc & (cnt1_ff == 8'h00);
  assign to01  = tick & ~wr_ctrl & ctrl_ff.en0 & ctrl_ff.casc & (cnt01 == 16'h0000);
  assign to23  = tick & ~wr_ctrl & ctrl_ff.en23 & (cnt23_ff == 16'h0000);
  assign toggle_output_mode_mode = pb_dir_ff[DPTP_TOGGLE_OUTPUT_MODE_BIT] & pb_sfr_ff[DPTP_TOGGLE_OUTPUT_MODE_BIT];

  // Reload choice: first expiry follows the pin in toggle mode, else low
  always_comb begin
    if (first_ff) begin
      sel_hi = toggle_output_mode_mode & ~pin_sync_ff;
    end else begin
      sel_hi = (phase_ff == DPTP_LOAD_HI);
    end
  end

  // Cascaded step always reloads, from the low or high pair
  assign nxt_cnt01 = dptp_step(cnt01, sel_hi ? rld_hi_ff : rld_lo_ff, 1'b1);

  // ************************************************************
  // First pair counters
  // ************************************************************
  // Software count write wins over a step in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt0_ff <= DPTP_BYTE_RST;
      cnt1_ff <= DPTP_BYTE_RST;
    end else if (wr_cnt01) begin
      cnt0_ff <= apb_req.pwdata[7:0];
      cnt1_ff <= apb_req.pwdata[15:8];
    end else if (tick && !wr_ctrl) begin
      if (ctrl_ff.casc) begin
        if (ctrl_ff.en0) begin
          {cnt1_ff, cnt0_ff} <= nxt_cnt01;
        end
      end else begin
        if (ctrl_ff.en0) begin
          cnt0_ff <= 8'(dptp_step({8'h00, cnt0_ff}, {8'h00, rld_lo_ff[7:0]},
                                  ctrl_ff.rld0));
        end
        if (ctrl_ff.en1) begin
          cnt1_ff <= 8'(dptp_step({8'h00, cnt1_ff}, {8'h00, rld_lo_ff[15:8]},
                                  ctrl_ff.rld1));
        end
      end
    end
  end

  // PWM phase; any control write, cascade set or not, arms the first expiry
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      phase_ff <= DPTP_LOAD_LO;
      first_ff <= 1'b1;
    end else if (wr_ctrl) begin
      first_ff <= 1'b1;
    end else if (to01) begin
      phase_ff <= sel_hi ? DPTP_LOAD_LO : DPTP_LOAD_HI;
      first_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Second pair counter
  // ************************************************************
  // Keeps counting regardless of pending requests; second zero is not tracked
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt23_ff <= DPTP_WORD_RST;
    end else if (wr_cnt23) begin
      cnt23_ff <= apb_req.pwdata[15:0];
    end else if (tick && !wr_ctrl && ctrl_ff.en23) begin
      cnt23_ff <= dptp_step(cnt23_ff, rld23_ff, 1'b1);
    end
  end

  // ************************************************************
  // Interrupts and toggle output
  // ************************************************************
  // One-cycle request pulses; low period ends on even, high on odd
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_even_ff <= 1'b0;
      irq_odd_ff  <= 1'b0;
      irq23_ff    <= 1'b0;
    end else begin
      irq_even_ff <= to0 | (to01 & sel_hi);
      irq_odd_ff  <= to1 | (to01 & ~sel_hi);
      irq23_ff    <= to23;
    end
  end
  assign even_timer_interrupt  = irq_even_ff;
  assign odd_timer_interrupt   = irq_odd_ff;
  assign second_pair_interrupt = irq23_ff;

  // Toggle on every even end-of-count; in PWM this tracks the period
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tog_ff <= 1'b0;
    end else if (to0 || to01) begin
      tog_ff <= ~tog_ff;
    end
  end
  // Pin only driven when software made it an output with the timer function
  assign timer_output_pin_o  = tog_ff;
  assign timer_output_pin_oe = toggle_output_mode_mode;

  // ************************************************************
  // Assertions
  // ************************************************************
  AST_TICK_PERIOD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (tick && !wr_ctrl) ##1 (!wr_ctrl) [*7] |=> tick)
    else $error("prescaler tick not every 8 clocks");

  AST_DISABLED_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!ctrl_ff.en0 && !ctrl_ff.en1 && !wr_cnt01) |=> $stable(cnt01))
    else $error("disabled first pair changed its count");

  AST_T0_DEC: assert property (@(posedge core_clk) disable iff (sys_rst)
    (tick && !wr_ctrl && !wr_cnt01 && ctrl_ff.en0 && !ctrl_ff.casc && cnt0_ff != 8'h00)
    |=> cnt0_ff == $past(cnt0_ff) - 8'h01)
    else $error("first even timer did not drop by one");

  AST_T0_WRAP: assert property (@(posedge core_clk) disable iff (sys_rst)
    (to0 && !ctrl_ff.rld0 && !wr_cnt01) |=> (cnt0_ff == 8'hFF) && irq_even_ff)
    else $error("independent timeout without reload mishandled");

  AST_T23_RELOAD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (to23 && !wr_cnt23 && !wr) |=> (cnt23_ff == rld23_ff) && second_pair_interrupt)
    else $error("second pair did not reload with its interrupt");

  AST_IRQ23_CAUSE: assert property (@(posedge core_clk) disable iff (sys_rst)
    second_pair_interrupt |-> $past(cnt23_ff) == 16'h0000 && $past(tick))
    else $error("second pair interrupt without full zero");

  AST_HIGH_PERIOD_RELOAD_LOAD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (to01 && sel_hi && !wr) |=> (cnt01 == rld_hi_ff) && even_timer_interrupt
    && !odd_timer_interrupt)
    else $error("end of low period mishandled");

  AST_PWM_ALT: assert property (@(posedge core_clk) disable iff (sys_rst)
    (to01 && !first_ff && !wr) |=> (phase_ff != $past(phase_ff)))
    else $error("pwm reload did not alternate");

  AST_CTRL_NO_LOAD: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_ctrl |=> $stable(cnt01) && $stable(cnt23_ff))
    else $error("control write changed a count");

  AST_TOGGLE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (to0 || to01) |=> tog_ff != $past(tog_ff))
    else $error("output did not toggle at end of count");

  AST_LOW_PERIOD_RELOAD_LOAD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (to01 && !sel_hi && !wr) |=> (cnt01 == rld_lo_ff) && odd_timer_interrupt
    && !even_timer_interrupt)
    else $error("end of high period mishandled");

  AST_PWM_FIRST_LO: assert property (@(posedge core_clk) disable iff (sys_rst)
    (to01 && first_ff && !toggle_output_mode_mode && !wr)
    |=> (cnt01 == rld_lo_ff) && odd_timer_interrupt)
    else $error("plain pwm did not start with the low value");

  AST_CASC_ONE_IRQ: assert property (@(posedge core_clk) disable iff (sys_rst)
    to01 |=> (even_timer_interrupt != odd_timer_interrupt))
    else $error("cascaded timeout raised no or two interrupts");

  AST_T23_DEC: assert property (@(posedge core_clk) disable iff (sys_rst)
    (tick && !wr_ctrl && !wr_cnt23 && ctrl_ff.en23 && cnt23_ff != 16'h0000)
    |=> cnt23_ff == $past(cnt23_ff) - 16'h0001)
    else $error("second pair did not drop by one");

  COV_PWM_FULL: cover property (@(posedge core_clk) disable iff (sys_rst)
    (to01 && sel_hi) ##[1:1000] (to01 && !sel_hi));
  COV_IND_BOTH: cover property (@(posedge core_clk) disable iff (sys_rst)
    to0 ##[1:1000] to1);
  COV_SECOND: cover property (@(posedge core_clk) disable iff (sys_rst)
    to23 ##[1:1000] to23);
  COV_FIRST_PIN_HIGH: cover property (@(posedge core_clk) disable iff (sys_rst)
    to01 && first_ff && toggle_output_mode_mode && pin_sync_ff);

endmodule // dptp_timer

// File: verif/dual_pair_timer_pwm_tb_top.sv
// Self-checking bench for the dual pair timer block: registers, timing, PWM and pin.
// Assumes the dptp_pkg map, a zero-wait APB slave and a pad that the bench resolves itself.
`timescale 1ns/1ps
module dual_pair_timer_pwm_tb_top;
  import dptp_pkg::*;

  // ************************************************************
  // Signals and stimulus table
  // ************************************************************
  typedef struct packed {
    logic [DPTP_ADDR_W-1:0] addr;
    logic [31:0]            wdat;
    logic [31:0]            rst_val;
    logic [31:0]            rd_val;
    logic                   err;
  } dptp_row_s;
  logic          core_clk = 1'b0;
  logic          sys_rst  = 1'b1;
  dptp_apb_req_s apb_req  = '0;
  logic          pad_drv  = 1'b0;
  logic          pready, pslverr, pin_i, pin_o, pin_oe;
  logic          irq_ev, irq_od, irq_sp;
  logic [31:0]   prdata, rd;
  logic [2:0]    seen;
  logic          er;
  int            num_errors = 0;
  int            n_compared = 0;
  int            ev_n = 0;
  int            cyc;
  int            ev_base;
  dptp_row_s     rows [9];

  // Clock at 200 MHz
  always #2.5 core_clk = ~core_clk;
  // Pad level: design drives it when enabled, else the bench does
  assign pin_i = pin_oe ? pin_o : pad_drv;
  // Even pulses, counted to prove the second pair never uses them
  always @(negedge core_clk) ev_n <= ev_n + int'(irq_ev === 1'b1);

  dptp_timer dptp_timer_i (
    .core_clk              (core_clk),
    .sys_rst               (sys_rst),
    .apb_req               (apb_req),
    .pready                (pready),
    .prdata                (prdata),
    .pslverr               (pslverr),
    .timer_output_pin_i    (pin_i),
    .timer_output_pin_o    (pin_o),
    .timer_output_pin_oe   (pin_oe),
    .even_timer_interrupt  (irq_ev),
    .odd_timer_interrupt   (irq_od),
    .second_pair_interrupt (irq_sp)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; an idle cycle always separates two transfers
  task automatic apb(input logic w, input logic [DPTP_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= w;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [DPTP_ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  // Cycles until any masked interrupt pulses, sampled mid-cycle
  task automatic wait_irq(input logic [2:0] m, input int lim);
    cyc = 0;
    seen = 3'b000;
    while (seen == 3'b000 && cyc < lim) begin
      @(negedge core_clk);
      cyc++;
      seen = {irq_sp, irq_od, irq_ev} & m;
    end
  endtask

  task automatic step(input logic [2:0] m, input int e);
    wait_irq(m, 3000);
    chk("pulse interval", 32'(e), 32'(cyc));
  endtask

  // A pulse that must come; running out of cycles is a mismatch
  task automatic expect_irq(input logic [2:0] m);
    wait_irq(m, 100);
    chk("pulse before limit", 32'h1, {31'h0, seen != 3'b000});
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard, far beyond the few thousand cycles the run needs
  initial begin
    #100us;
    num_errors++;
    end_of_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rows[0] = '{DPTP_OFS_CNT01,  32'hFFFF_A55A, 32'h0, 32'h0000_A55A, 1'b0};
    rows[1] = '{DPTP_OFS_CNT23,  32'h0000_1234, 32'h0, 32'h0000_1234, 1'b0};
    rows[2] = '{DPTP_OFS_RLDLO,  32'h0000_BEEF, 32'h0, 32'h0000_BEEF, 1'b0};
    rows[3] = '{DPTP_OFS_RLDHI,  32'h0000_C0DE, 32'h0, 32'h0000_C0DE, 1'b0};
    rows[4] = '{DPTP_OFS_RLD23,  32'h0000_7E81, 32'h0, 32'h0000_7E81, 1'b0};
    rows[5] = '{DPTP_OFS_PB_DIR, 32'h0000_01FF, 32'h0, 32'h0000_00FF, 1'b0};
    rows[6] = '{DPTP_OFS_PB_SFR, 32'h0000_0002, 32'h0, 32'h0000_0002, 1'b0};
    rows[7] = '{DPTP_OFS_CTRL,   32'hFFFF_FFC0, 32'h0, 32'h0000_0000, 1'b0};
    rows[8] = '{12'h020,         32'h0000_0005, 32'h0, 32'h0000_0000, 1'b1};
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    chk("oe after reset", 32'h0, {31'h0, pin_oe});
    rchk("stat reset", DPTP_OFS_STAT, 32'h0000_0004);
    // Reset value, write, read back and slave error for every row
    foreach (rows[i]) begin
      rchk("reset value", rows[i].addr, rows[i].rst_val);
      apb(1'b1, rows[i].addr, rows[i].wdat);
      rchk("read back", rows[i].addr, rows[i].rd_val);
      chk("slave error", {31'h0, rows[i].err}, {31'h0, er});
    end
    chk("oe with dir and sfr", 32'h1, {31'h0, pin_oe});
    // Disabled timers hold their counts
    wait_irq(3'b111, 60);
    chk("no pulse while disabled", 32'h0, {29'h0, seen});
    rchk("count held", DPTP_OFS_CNT01, 32'h0000_A55A);
    // Independent 8-bit pair with reload and toggle output
    do_reset();
    apb(1'b1, DPTP_OFS_CNT01, 32'h0000_0302);
    apb(1'b1, DPTP_OFS_RLDLO, 32'h0000_0201);
    apb(1'b1, DPTP_OFS_PB_DIR, 32'h0000_0002);
    apb(1'b1, DPTP_OFS_PB_SFR, 32'h0000_0002);
    apb(1'b1, DPTP_OFS_CTRL, 32'h0000_0033);
    rchk("count after enable", DPTP_OFS_CNT01, 32'h0000_0302);
    expect_irq(3'b001);
    chk("even first pin", 32'h1, {31'h0, pin_o});
    step(3'b001, 16);
    chk("even second pin", 32'h0, {31'h0, pin_o});
    expect_irq(3'b010);
    step(3'b010, 24);
    // Reload off: the even counter wraps instead
    apb(1'b1, DPTP_OFS_CTRL, 32'h0000_0003);
    expect_irq(3'b001);
    apb(1'b0, DPTP_OFS_CNT01, 32'h0000_0000);
    chk("wrap without reload", 32'h0000_00FF, rd & 32'h0000_00FF);
    // PWM in toggle mode: low pad at first expiry picks the high value
    do_reset();
    apb(1'b1, DPTP_OFS_RLDLO, 32'h0000_0001);
    apb(1'b1, DPTP_OFS_RLDHI, 32'h0000_0003);
    apb(1'b1, DPTP_OFS_PB_DIR, 32'h0000_0002);
    apb(1'b1, DPTP_OFS_PB_SFR, 32'h0000_0002);
    apb(1'b1, DPTP_OFS_CTRL, 32'h0000_0009);
    wait_irq(3'b011, 100);
    chk("first toggle expiry", 32'h1, {29'h0, seen});
    chk("pin after low end", 32'h1, {31'h0, pin_o});
    step(3'b010, 32);
    chk("pin after high end", 32'h0, {31'h0, pin_o});
    step(3'b001, 16);
    chk("pin after low end", 32'h1, {31'h0, pin_o});
    // Re-armed with the pin high: the first expiry ends a high period
    apb(1'b1, DPTP_OFS_CTRL, 32'h0000_0009);
    wait_irq(3'b011, 100);
    chk("first expiry pin high", 32'h2, {29'h0, seen});
    chk("pin after high end", 32'h0, {31'h0, pin_o});
    // PWM without toggle mode: low value first even with a low pad
    do_reset();
    pad_drv <= 1'b0;
    apb(1'b1, DPTP_OFS_RLDLO, 32'h0000_0001);
    apb(1'b1, DPTP_OFS_RLDHI, 32'h0000_0003);
    apb(1'b1, DPTP_OFS_CTRL, 32'h0000_0009);
    wait_irq(3'b011, 100);
    chk("first plain expiry", 32'h2, {29'h0, seen});
    step(3'b001, 16);
    step(3'b010, 32);
    // Second pair as one 16-bit timer, reload bits clear
    do_reset();
    apb(1'b1, DPTP_OFS_CNT23, 32'h0000_0100);
    apb(1'b1, DPTP_OFS_RLD23, 32'h0000_0001);
    ev_base = ev_n;
    apb(1'b1, DPTP_OFS_CTRL, 32'h0000_0004);
    // 257 ticks of 8 clocks after the write edge, seen one half cycle later
    wait_irq(3'b100, 2200);
    chk("borrow across bytes", 32'h0000_0809, 32'(cyc));
    step(3'b100, 16);
    step(3'b100, 16);
    chk("even quiet", 32'(ev_base), 32'(ev_n));
    // Reset in mid-run stops everything
    do_reset();
    rchk("count cleared", DPTP_OFS_CNT23, 32'h0);
    rchk("control cleared", DPTP_OFS_CTRL, 32'h0);
    wait_irq(3'b111, 60);
    chk("quiet after reset", 32'h0, {29'h0, seen});
    end_of_test();
  end
endmodule // dual_pair_timer_pwm_tb_top
